// ===== hdl/nvm_ctrl.sv
// APB register block and control for self-programming of flash, EEPROM and config space
//
// The implementer's own choices: the register offsets and the APB slave port.
module nvm_ctrl import nvm_pkg::*; #(
	parameter int WINDOW_CYC = KEY_WINDOW_CYC
) (
	input  wire logic        SYS_CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             NVM_REQ_O,
	output logic             NVM_WRITE_O,
	output logic             NVM_ERASE_O,
	output logic             NVM_LATCH_ONLY_O,
	output logic             NVM_FLASH_SEL_O,
	output logic             NVM_CFG_SEL_O,
	output logic      [14:0] NVM_ADDR_O,
	output logic      [13:0] NVM_WDATA_O,
	input  wire logic [13:0] NVM_RDATA_I,
	input  wire logic        NVM_DONE_I,
	input  wire logic        NVM_ABORT_I,
	output logic             IRQ_O
);
	logic [7:0]  ctrl_ff;
	logic [7:0]  nxt_ctrl;
	logic [7:0]  addr_lo_ff;
	logic [7:0]  nxt_addr_lo;
	logic [6:0]  addr_hi_ff;
	logic [6:0]  nxt_addr_hi;
	logic [7:0]  data_lo_ff;
	logic [7:0]  nxt_data_lo;
	logic [5:0]  data_hi_ff;
	logic [5:0]  nxt_data_hi;
	logic [IRQ_WIDTH-1:0] stat_ff;
	logic [IRQ_WIDTH-1:0] nxt_stat;
	logic [IRQ_WIDTH-1:0] mask_ff;
	logic [IRQ_WIDTH-1:0] nxt_mask;
	logic [31:0] nxt_rdata;
	op_e         op_ff;
	op_e         nxt_op;
	logic        access;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic        key_wr;
	logic        start_req;
	logic        armed;
	logic        launch;
	logic        consume;
	logic [7:0]  wbyte;

	assign access  = PSEL_I && PENABLE_I;
	assign wr_acc  = access && PWRITE_I;
	assign rd_acc  = access && !PWRITE_I;
	assign wbyte   = low8(PWDATA_I);
	assign key_wr  = wr_acc && PADDR_I == OFS_UNLOCK;
	assign start_req = wr_acc && PADDR_I == OFS_CONTROL && wbyte[BIT_START]
		&& !ctrl_ff[BIT_START] && op_ff == OP_IDLE;
	// Launch needs a live unlock and write permit; otherwise the attempt is refused
	assign launch  = start_req && armed && wbyte[BIT_PERMIT];
	assign consume = launch;

	always_comb begin
		unique case (PADDR_I)
			OFS_CONTROL, OFS_UNLOCK, OFS_ADDR_LOW, OFS_ADDR_HIGH,
			OFS_DATA_LOW, OFS_DATA_HIGH, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	nvm_unlock_seq #(
		.WINDOW_CYC(WINDOW_CYC)
	) nvm_unlock_seq_i (
		.clk_i     (SYS_CLK_I),
		.nrst_i    (NRST_I),
		.key_wr_i  (key_wr),
		.key_data_i(wbyte),
		.start_wr_i(start_req && !launch),
		.consume_i (consume),
		.armed_o   (armed)
	);

	always_comb begin
		nxt_ctrl    = ctrl_ff;
		nxt_addr_lo = addr_lo_ff;
		nxt_addr_hi = addr_hi_ff;
		nxt_data_lo = data_lo_ff;
		nxt_data_hi = data_hi_ff;
		nxt_mask    = mask_ff;
		nxt_op      = op_ff;
		nxt_stat    = stat_ff;
		if (rd_acc && PADDR_I == OFS_IRQ_STAT) begin
			nxt_stat = '0;
		end
		if (wr_acc) begin
			unique case (PADDR_I)
				OFS_CONTROL: begin
					nxt_ctrl[BIT_FLASH_SEL]  = wbyte[BIT_FLASH_SEL];
					nxt_ctrl[BIT_CFG_SEL]    = wbyte[BIT_CFG_SEL];
					nxt_ctrl[BIT_LATCH_ONLY] = wbyte[BIT_LATCH_ONLY];
					nxt_ctrl[BIT_ERASE_SEL]  = wbyte[BIT_ERASE_SEL];
					nxt_ctrl[BIT_ABORT]      = wbyte[BIT_ABORT];
					nxt_ctrl[BIT_PERMIT]     = wbyte[BIT_PERMIT];
				end
				OFS_ADDR_LOW:  nxt_addr_lo = wbyte;
				OFS_ADDR_HIGH: nxt_addr_hi = wbyte[6:0];
				OFS_DATA_LOW:  nxt_data_lo = wbyte;
				OFS_DATA_HIGH: nxt_data_hi = wbyte[5:0];
				OFS_IRQ_MASK:  nxt_mask = wbyte[IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
		// Read start: software-set, hardware-clear; started only when idle
		if (wr_acc && PADDR_I == OFS_CONTROL && wbyte[BIT_READ] && op_ff == OP_IDLE
			&& !start_req) begin
			nxt_ctrl[BIT_READ] = 1'b1;
			nxt_op = OP_READ;
		end
		if (launch) begin
			nxt_ctrl[BIT_START] = 1'b1;
			nxt_op = OP_WRITE;
		end
		if (op_ff != OP_IDLE && NVM_DONE_I) begin
			if (op_ff == OP_READ) begin
				nxt_data_lo = NVM_RDATA_I[7:0];
				nxt_data_hi = NVM_RDATA_I[13:8];
				nxt_ctrl[BIT_READ] = 1'b0;
			end else begin
				nxt_ctrl[BIT_START] = 1'b0;
				nxt_ctrl[BIT_ERASE_SEL] = 1'b0;
			end
			nxt_op = OP_IDLE;
			nxt_stat[IRQ_DONE] = 1'b1;
		end
		// Abort of a write sets the error flag and ends the operation; an abort during a read is ignored
		if (op_ff == OP_WRITE && NVM_ABORT_I) begin
			nxt_ctrl[BIT_ABORT] = 1'b1;
			nxt_ctrl[BIT_START] = 1'b0;
			nxt_op = OP_IDLE;
			nxt_stat[IRQ_ABORT] = 1'b1;
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (rd_acc) begin
			unique case (PADDR_I)
				OFS_CONTROL:   nxt_rdata[7:0] = ctrl_ff;
				OFS_UNLOCK:    nxt_rdata[7:0] = 8'h00;
				OFS_ADDR_LOW:  nxt_rdata[7:0] = addr_lo_ff;
				OFS_ADDR_HIGH: nxt_rdata[7:0] = ADDR_HIGH_TOP_ONE | {1'b0, addr_hi_ff};
				OFS_DATA_LOW:  nxt_rdata[7:0] = data_lo_ff;
				OFS_DATA_HIGH: nxt_rdata[7:0] = {2'b00, data_hi_ff};
				OFS_IRQ_STAT:  nxt_rdata[IRQ_WIDTH-1:0] = stat_ff;
				OFS_IRQ_MASK:  nxt_rdata[IRQ_WIDTH-1:0] = mask_ff;
				default:       nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			ctrl_ff    <= CONTROL_RESET;
			addr_lo_ff <= 8'h00;
			addr_hi_ff <= 7'h00;
			data_lo_ff <= 8'h00;
			data_hi_ff <= 6'h00;
			stat_ff    <= '0;
			mask_ff    <= '0;
			op_ff      <= OP_IDLE;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			addr_lo_ff <= nxt_addr_lo;
			addr_hi_ff <= nxt_addr_hi;
			data_lo_ff <= nxt_data_lo;
			data_hi_ff <= nxt_data_hi;
			stat_ff    <= nxt_stat;
			mask_ff    <= nxt_mask;
			op_ff      <= nxt_op;
		end
	end

	// Reads are combinational so the access phase finishes in one cycle
	assign PRDATA_O  = (rd_acc) ? nxt_rdata : 32'h0000_0000;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access && !mapped;

	assign NVM_REQ_O        = op_ff != OP_IDLE;
	assign NVM_WRITE_O      = op_ff == OP_WRITE;
	assign NVM_ERASE_O      = ctrl_ff[BIT_ERASE_SEL];
	assign NVM_LATCH_ONLY_O = ctrl_ff[BIT_LATCH_ONLY];
	assign NVM_FLASH_SEL_O  = ctrl_ff[BIT_FLASH_SEL];
	assign NVM_CFG_SEL_O    = ctrl_ff[BIT_CFG_SEL];
	assign NVM_ADDR_O       = {addr_hi_ff, addr_lo_ff};
	assign NVM_WDATA_O      = {data_hi_ff, data_lo_ff};
	assign IRQ_O            = |(stat_ff & mask_ff);

	chk_start_needs_unlock: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		$rose(NVM_WRITE_O) |-> $past(armed) && $past(wbyte[BIT_PERMIT]))
		else $error("write launched without unlock");
	chk_start_clear_done: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		op_ff == OP_WRITE && NVM_DONE_I && !NVM_ABORT_I |=> !ctrl_ff[BIT_START] && !NVM_REQ_O)
		else $error("start bit not cleared at completion");
	chk_addr_high_one: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		rd_acc && PADDR_I == OFS_ADDR_HIGH |-> PRDATA_O[7] && PRDATA_O[31:8] == 24'h000000)
		else $error("address high top bit not one");
	chk_key_reads_zero: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		rd_acc && PADDR_I == OFS_UNLOCK |-> PRDATA_O == 32'h0000_0000)
		else $error("key port returned data");
	chk_data_high_top: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		rd_acc && PADDR_I == OFS_DATA_HIGH |-> PRDATA_O[31:6] == 26'h0000000)
		else $error("data high top bits not zero");
	chk_addr_lo_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		wr_acc && PADDR_I == OFS_ADDR_LOW |=> NVM_ADDR_O[7:0] == $past(wbyte))
		else $error("address low not taken");
	chk_addr_hi_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		wr_acc && PADDR_I == OFS_ADDR_HIGH |=> NVM_ADDR_O[14:8] == $past(wbyte[6:0]))
		else $error("address high not taken");
	chk_read_data_load: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		op_ff == OP_READ && NVM_DONE_I |=> NVM_WDATA_O == $past(NVM_RDATA_I))
		else $error("read data not captured");
	chk_data_hi_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		wr_acc && PADDR_I == OFS_DATA_HIGH && op_ff == OP_IDLE
		|=> NVM_WDATA_O[13:8] == $past(wbyte[5:0]))
		else $error("data high not taken");
	chk_key_no_store: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		key_wr |=> ctrl_ff == $past(ctrl_ff) || $past(op_ff) != OP_IDLE)
		else $error("key write changed control");
	chk_abort_flag_set: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		op_ff == OP_WRITE && NVM_ABORT_I |=> ctrl_ff[BIT_ABORT] && !NVM_REQ_O)
		else $error("abort did not set error flag");
	chk_read_bit_clear: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		op_ff == OP_READ && NVM_DONE_I |=> !ctrl_ff[BIT_READ] && !NVM_REQ_O)
		else $error("read bit not cleared at completion");

	cov_write_launch: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) launch);
	cov_read_done: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		op_ff == OP_READ && NVM_DONE_I);
	cov_abort: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		op_ff == OP_WRITE && NVM_ABORT_I);
	cov_irq: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) $rose(IRQ_O));
endmodule // nvm_ctrl

// ===== include/nvm_pkg.sv
// Register map, field positions and timing constants of the self-programming control unit
package nvm_pkg;
	localparam logic [11:0] OFS_CONTROL   = 12'h000;
	localparam logic [11:0] OFS_UNLOCK    = 12'h004;
	localparam logic [11:0] OFS_ADDR_LOW  = 12'h008;
	localparam logic [11:0] OFS_ADDR_HIGH = 12'h00c;
	localparam logic [11:0] OFS_DATA_LOW  = 12'h010;
	localparam logic [11:0] OFS_DATA_HIGH = 12'h014;
	localparam logic [11:0] OFS_IRQ_STAT  = 12'h018;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h01c;

	localparam int BIT_FLASH_SEL  = 7;
	localparam int BIT_CFG_SEL    = 6;
	localparam int BIT_LATCH_ONLY = 5;
	localparam int BIT_ERASE_SEL  = 4;
	localparam int BIT_ABORT      = 3;
	localparam int BIT_PERMIT     = 2;
	localparam int BIT_START      = 1;
	localparam int BIT_READ       = 0;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] ADDR_HIGH_TOP_ONE = 8'h80;
	localparam logic [7:0] DATA_HIGH_MASK    = 8'h3f;
	localparam logic [7:0] ADDR_HIGH_MASK    = 8'h7f;
	localparam logic [7:0] CONTROL_RESET     = 8'h00;

	// Interrupt status bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_WIDTH = 2;

	// Unlock window: each step must follow the previous within this time
	localparam int CLK_HZ          = 40_000_000;
	localparam int KEY_WINDOW_NS   = 1000;
	localparam int KEY_WINDOW_CYC  = (KEY_WINDOW_NS * (CLK_HZ / 1_000_000)) / 1000;

	typedef enum {ST_LOCKED, ST_KEY1, ST_ARMED} unlock_e;
	typedef enum {OP_IDLE, OP_WRITE, OP_READ} op_e;

	function automatic logic [7:0] low8(input logic [31:0] w);
		return w[7:0];
	endfunction
endpackage

// ===== hdl/nvm_unlock_seq.sv
// Unlock key sequencer: 55h then AAh, then program-start, each step in a time window
module nvm_unlock_seq import nvm_pkg::*; #(
	parameter int WINDOW_CYC = KEY_WINDOW_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       key_wr_i,
	input  wire logic [7:0] key_data_i,
	input  wire logic       start_wr_i,
	input  wire logic       consume_i,
	output logic            armed_o
);
	unlock_e     state_ff;
	unlock_e     nxt_state;
	logic [15:0] timer_ff;
	logic [15:0] nxt_timer;

	always_comb begin
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		if (state_ff != ST_LOCKED) begin
			if (timer_ff == 16'h0000) begin
				nxt_state = ST_LOCKED;
			end else begin
				nxt_timer = timer_ff - 16'h0001;
			end
		end
		if (key_wr_i) begin
			// Key value only drives this sequencer, nothing is stored
			if (key_data_i == KEY_FIRST) begin
				nxt_state = ST_KEY1;
				nxt_timer = 16'(WINDOW_CYC);
			end else if (key_data_i == KEY_SECOND && state_ff == ST_KEY1) begin
				nxt_state = ST_ARMED;
				nxt_timer = 16'(WINDOW_CYC);
			end else begin
				nxt_state = ST_LOCKED;
			end
		end else if (start_wr_i || consume_i) begin
			nxt_state = ST_LOCKED; // One start per unlock
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_ff <= ST_LOCKED;
			timer_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
		end
	end

	assign armed_o = (state_ff == ST_ARMED);

	chk_armed_needs_key: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(armed_o) |-> $past(key_wr_i) && $past(key_data_i) == KEY_SECOND)
		else $error("armed without second key");
	chk_window_expiry: assert property (@(posedge clk_i) disable iff (!nrst_i)
		armed_o && !key_wr_i && !start_wr_i && !consume_i && timer_ff == 16'h0000 |=> !armed_o)
		else $error("unlock window not enforced");
	cov_armed: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(armed_o));
endmodule // nvm_unlock_seq

// ===== tb/nvm_ctrl_test.sv
// Self-checking bench for the self-programming control unit
module nvm_ctrl_test import nvm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          WIN  = 8;
	localparam logic [31:0] GO   = (32'h1 << BIT_START) | (32'h1 << BIT_PERMIT);
	localparam logic [31:0] BAD  = 32'h0000_0020;

	logic        clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        req;
	logic        wr;
	logic        erase;
	logic        latch;
	logic        fsel;
	logic        csel;
	logic [14:0] addr;
	logic [13:0] wdata;
	logic [13:0] rdata;
	logic        done;
	logic        abort;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          err_count;
	int          num_checks;
	int          cycles = 0;

	nvm_ctrl #(.WINDOW_CYC(WIN)) nvm_ctrl_i (
		.SYS_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .NVM_REQ_O(req), .NVM_WRITE_O(wr),
		.NVM_ERASE_O(erase), .NVM_LATCH_ONLY_O(latch), .NVM_FLASH_SEL_O(fsel),
		.NVM_CFG_SEL_O(csel), .NVM_ADDR_O(addr), .NVM_WDATA_O(wdata),
		.NVM_RDATA_I(rdata), .NVM_DONE_I(done), .NVM_ABORT_I(abort), .IRQ_O(irq)
	);

	always #12.5 clk = ~clk;

	task automatic conclude();
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			conclude();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic unlock();
		apb(1'b1, OFS_UNLOCK, 32'(KEY_FIRST));
		apb(1'b1, OFS_UNLOCK, 32'(KEY_SECOND));
	endtask

	// Array side answers with a one-cycle pulse, then the unit settles
	task automatic pulse(input logic ab);
		@(posedge clk);
		done  <= !ab;
		abort <= ab;
		@(posedge clk);
		done  <= 1'b0;
		abort <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		rdata = '0;
		done = 1'b0;
		abort = 1'b0;
		err_count = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(OFS_CONTROL, 32'h0, "control reset");
		rd_chk(OFS_ADDR_HIGH, 32'h80, "addr high reset");
		rd_chk(OFS_DATA_HIGH, 32'h0, "data high reset");
		check("irq reset", 32'(irq), 32'h0);
		apb(1'b1, OFS_ADDR_LOW, 32'hffff_ffa5);
		apb(1'b1, OFS_ADDR_HIGH, 32'hffff_ffda);
		apb(1'b1, OFS_DATA_LOW, 32'h3c);
		apb(1'b1, OFS_DATA_HIGH, 32'hff);
		rd_chk(OFS_ADDR_LOW, 32'ha5, "addr low");
		rd_chk(OFS_ADDR_HIGH, 32'hda, "addr high");
		rd_chk(OFS_DATA_HIGH, 32'h3f, "data high");
		check("array address", 32'(addr), 32'h5aa5);
		check("array wdata", 32'(wdata), 32'h3f3c);
		apb(1'b1, OFS_ADDR_HIGH, 32'h0);
		rd_chk(OFS_ADDR_HIGH, 32'h80, "addr high top");
		apb(1'b0, BAD[11:0], 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped err", 32'(er), 32'h1);
		apb(1'b1, OFS_UNLOCK, 32'(KEY_FIRST));
		rd_chk(OFS_UNLOCK, 32'h0, "key readback");
		// Refused: no key, wrong second key, late second key, late start, no permit
		for (int k = 0; k < 5; k++) begin
			repeat (WIN + 4) @(posedge clk);
			if (k > 0) apb(1'b1, OFS_UNLOCK, 32'(KEY_FIRST));
			if (k == 2) repeat (WIN + 4) @(posedge clk);
			if (k > 0) apb(1'b1, OFS_UNLOCK, (k == 1) ? 32'h33 : 32'(KEY_SECOND));
			if (k == 3) repeat (WIN + 4) @(posedge clk);
			apb(1'b1, OFS_CONTROL, (k == 4) ? (32'h1 << BIT_START) : GO);
			@(posedge clk);
			check("refused start", 32'(req), 32'h0);
		end
		apb(1'b1, OFS_IRQ_MASK, 32'h3);
		unlock();
		apb(1'b1, OFS_CONTROL, GO | 32'h80);
		@(posedge clk);
		check("write launched", 32'({req, wr, fsel}), 32'h7);
		rd_chk(OFS_CONTROL, 32'h86, "start set");
		pulse(1'b0);
		check("write ended", 32'(req), 32'h0);
		rd_chk(OFS_CONTROL, 32'h84, "start cleared");
		check("irq done", 32'(irq), 32'h1);
		rd_chk(OFS_IRQ_STAT, 32'h1, "status done");
		@(posedge clk);
		check("irq cleared", 32'(irq), 32'h0);
		rd_chk(OFS_IRQ_STAT, 32'h0, "status cleared");
		rdata <= 14'h2abc;
		apb(1'b1, OFS_CONTROL, 32'h1 << BIT_READ);
		@(posedge clk);
		check("read launched", 32'({req, wr}), 32'h2);
		pulse(1'b0);
		rd_chk(OFS_DATA_LOW, 32'hbc, "read low");
		rd_chk(OFS_DATA_HIGH, 32'h2a, "read high");
		rd_chk(OFS_IRQ_STAT, 32'h1, "status read");
		apb(1'b1, OFS_IRQ_MASK, 32'h0);
		unlock();
		apb(1'b1, OFS_CONTROL, GO | (32'h1 << BIT_ERASE_SEL));
		@(posedge clk);
		check("erase launched", 32'({req, wr, erase}), 32'h7);
		pulse(1'b1);
		check("aborted", 32'({req, irq}), 32'h0);
		apb(1'b1, OFS_IRQ_MASK, 32'h2);
		@(posedge clk);
		check("irq abort", 32'(irq), 32'h1);
		rd_chk(OFS_IRQ_STAT, 32'h2, "status abort");
		rd_chk(OFS_CONTROL, 32'h1c, "control after abort");
		check("abort flag", 32'(rd[BIT_ABORT]), 32'h1);
		apb(1'b1, OFS_CONTROL, 32'h60);
		@(posedge clk);
		check("space selects", 32'({csel, latch, irq}), 32'h6);
		conclude();
	end
endmodule // nvm_ctrl_test
